// ### common/mrs_pkg.sv
// constants and types shared by the memory reference sequencer
package mrs_pkg;
  localparam int W = 18;
  localparam int PW = 6;
  localparam int CNT_W = 4;
  localparam int CS_DEPTH_DEF = 64;
  localparam int NPORT_DEF = 8;
  localparam logic [PW-1:0] LOC_LAST = 6'h1f;
  localparam logic [PW-1:0] EXT_LAST = 6'h27;
  // timing in ns and derived pclk counts (least times round up)
  localparam int CLK_NS = 100;
  localparam int GO_GATE_NS = 640;
  localparam int GO_GO_NS = 800;
  localparam int RES_GO_NS = 400;
  localparam logic [CNT_W-1:0] GO_GATE_CYC = CNT_W'((GO_GATE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] GO_GO_CYC = CNT_W'((GO_GO_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] RES_GO_CYC = CNT_W'((RES_GO_NS + CLK_NS - 1) / CLK_NS);
  // apb byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_BASE = 8'h04;
  localparam logic [7:0] A_LIMIT = 8'h08;
  localparam logic [7:0] A_SIZE = 8'h0c;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_COD = 8'h14;
  // reset values and status bit positions
  localparam logic CTRL_RST = 1'h1;
  localparam logic [W-1:0] BASE_RST = 18'h0;
  localparam logic [W-1:0] LIMIT_RST = 18'h3ffff;
  localparam logic [W:0] SIZE_RST = 19'h40000;
  localparam int ST_BUSY = 0;
  localparam int ST_READY = 1;
  localparam int ST_PCHK = 2;
  // pointer classes
  localparam logic [1:0] PC_LOCAL = 2'h0;
  localparam logic [1:0] PC_EXT = 2'h1;
  localparam logic [1:0] PC_NONE = 2'h2;
  typedef enum logic [2:0] {
    SRC_PTR_REG, SRC_OUT_BUS, SRC_MC, SRC_MC1, SRC_MC2, SRC_MC_B, SRC_BASE_AB, SRC_INDEX
  } cs_src_t;
  typedef enum logic [1:0] {MS_IDLE, MS_FETCH, MS_WAITRES, MS_DONE} ms_state_t;
endpackage

// ### verilog/memory_reference_sequencer.sv
// memory reference and external operation sequencer with apb control
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - control store address picked by 3-bit source field of the same vector
// - address needed only in the access step, latched at leading edge
// - every access drives the word on the output bus; missing location gives zero
// - read and write together perform only the write
// - read data usable next trailing edge and held until next access
// - write stores the write-data register and echoes it on the output bus
// - main read word at address plus base, gated onto output bus once ready
// - address above limit or beyond installed store gives zero and check
// - unprotected mode uses zero base, all-ones limit; overflow gives ones
// - pointers 0-31 local, 32-39 external, above is ones or null
// - go ignored while busy; go-gate, go-go and resume-go minimum gaps
// - port read pulses selected port and loads the 18 incoming lines
// - port transmit pulses the already selected port
module memory_reference_sequencer #(
  parameter int CS_DEPTH = mrs_pkg::CS_DEPTH_DEF,
  parameter int NPORT = mrs_pkg::NPORT_DEF
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // step timing and control store commands
  input wire logic t_step,
  input wire logic cs_read_cmd,
  input wire logic cs_write_cmd,
  input wire logic [2:0] cs_addr_sel,
  // control store address and data sources
  input wire logic [mrs_pkg::W-1:0] ctrl_addr_bus,
  input wire logic [mrs_pkg::W-1:0] micro_counter,
  input wire logic [mrs_pkg::W-1:0] parameter_register,
  input wire logic [mrs_pkg::W-1:0] micro_base_bus,
  input wire logic [mrs_pkg::W-1:0] index_result,
  input wire logic [mrs_pkg::W-1:0] ctrl_write_data_bus,
  output logic [mrs_pkg::W-1:0] ctrl_output_bus,
  // main store commands and buses
  input wire logic main_go_cmd,
  input wire logic main_resume_cmd,
  input wire logic main_data_gate_cmd,
  input wire logic unprotected_main_mode,
  input wire logic [mrs_pkg::PW-1:0] main_input_pointer,
  input wire logic [mrs_pkg::PW-1:0] main_output_pointer,
  input wire logic [mrs_pkg::W-1:0] main_local_data,
  input wire logic [mrs_pkg::W-1:0] main_ext_data,
  output logic main_busy_test,
  output logic main_data_ready_test,
  output logic [mrs_pkg::W-1:0] main_output_bus,
  output logic main_local_we,
  output logic main_ext_we,
  output logic [mrs_pkg::PW-1:0] main_dest_sel,
  output logic program_check,
  // main store memory
  output logic ms_req,
  output logic ms_we,
  output logic [mrs_pkg::W-1:0] ms_addr,
  output logic [mrs_pkg::W-1:0] ms_wdata,
  input wire logic [mrs_pkg::W-1:0] ms_rdata,
  input wire logic ms_rvalid,
  // external ports
  input wire logic [$clog2(NPORT)-1:0] port_select_field,
  input wire logic port_read_cmd,
  input wire logic port_transmit_cmd,
  input wire logic [mrs_pkg::W-1:0] port_data_in,
  output logic [NPORT-1:0] port_read_strobe,
  output logic [NPORT-1:0] port_transmit_strobe,
  output logic [mrs_pkg::W-1:0] port_capture
);
  import mrs_pkg::*;
  localparam int AW = $clog2(CS_DEPTH);

  // pointer decode shared by the input and output pointers
  function automatic logic [1:0] ptr_class(input logic [PW-1:0] p);
    if (p <= LOC_LAST) return PC_LOCAL;
    else if (p <= EXT_LAST) return PC_EXT;
    else return PC_NONE;
  endfunction

  logic ctrl_reg, ctrl_next;
  logic [W-1:0] base_reg, base_next, limit_reg, limit_next;
  logic [W:0] size_reg, size_next;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next, wr_acc, pchk_clr;

  // control store
  logic [W-1:0] cs_mem [CS_DEPTH];
  logic [W-1:0] cod_reg, cod_next, cs_addr;
  logic cs_oob, cs_rd, cs_wr;

  // address source select, sampled only at the leading edge
  always_comb begin
    case (cs_src_t'(cs_addr_sel))
      SRC_PTR_REG: cs_addr = ctrl_addr_bus;
      SRC_OUT_BUS: cs_addr = cod_reg;
      SRC_MC: cs_addr = micro_counter;
      SRC_MC1: cs_addr = micro_counter + 18'h1;
      SRC_MC2: cs_addr = micro_counter + 18'h2;
      SRC_MC_B: cs_addr = micro_counter + {12'h0, parameter_register[5:0]};
      SRC_BASE_AB: cs_addr = micro_base_bus + {6'h0, parameter_register[11:0]};
      default: cs_addr = index_result;
    endcase
  end

  assign cs_oob = cs_addr >= W'(CS_DEPTH);
  assign cs_wr = t_step & cs_write_cmd;
  // write takes priority over a read in the same step
  assign cs_rd = t_step & cs_read_cmd & ~cs_write_cmd;

  // output bus only moves on an access, so it doubles as an address source
  always_comb begin
    cod_next = cod_reg;
    if (cs_wr) begin
      cod_next = cs_oob ? '0 : ctrl_write_data_bus;
    end else if (cs_rd) begin
      cod_next = cs_oob ? '0 : cs_mem[cs_addr[AW-1:0]];
    end
  end

  // address used in the access cycle only, later changes are harmless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cod_reg <= '0;
      for (int i = 0; i < CS_DEPTH; i++) cs_mem[i] <= '0;
    end else begin
      cod_reg <= cod_next;
      if (cs_wr && !cs_oob) cs_mem[cs_addr[AW-1:0]] <= ctrl_write_data_bus;
    end
  end

  // main store
  ms_state_t st_reg, st_next;
  logic [W-1:0] maddr_reg, maddr_next, data_reg, data_next, wdat_reg, wdat_next, mob_reg, mob_next;
  logic [W-1:0] main_in, eff_base, eff_lim;
  logic [W:0] ms_sum;
  logic [CNT_W-1:0] go_cnt_reg, go_cnt_next, res_cnt_reg, res_cnt_next;
  logic wr_reg, wr_next, flt_reg, flt_next, pend_reg, pend_next, got_reg, got_next;
  logic rdy_reg, rdy_next, busy_reg, busy_next, req_reg, req_next, we_reg, we_next;
  logic pchk_reg, pchk_next, stk_reg, stk_next, lwe_reg, lwe_next, ewe_reg, ewe_next;
  logic [PW-1:0] dsel_reg, dsel_next;
  logic prot, ms_bad, go_ok, res_take, gate_ok;

  // input bus: local, external or all ones beyond both
  always_comb begin
    case (ptr_class(main_input_pointer))
      PC_LOCAL: main_in = main_local_data;
      PC_EXT: main_in = main_ext_data;
      default: main_in = '1;
    endcase
  end

  // protection off behaves as base zero and limit all ones
  assign prot = ctrl_reg & ~unprotected_main_mode;
  assign eff_base = prot ? base_reg : '0;
  assign eff_lim = prot ? limit_reg : '1;
  assign ms_sum = {1'b0, main_in} + {1'b0, eff_base};
  assign ms_bad = (main_in > eff_lim) | (ms_sum >= size_reg);
  assign go_ok = t_step & main_go_cmd & ~busy_reg;
  assign res_take = (st_reg == MS_FETCH) & wr_reg & ~pend_reg & t_step & main_resume_cmd;
  assign gate_ok = t_step & main_data_gate_cmd & rdy_reg;

  // one memory cycle at a time; a go reads unless the address is bad, so the word can be gated
  always_comb begin
    st_next = st_reg;
    maddr_next = maddr_reg;
    data_next = data_reg;
    wdat_next = wdat_reg;
    wr_next = wr_reg;
    flt_next = flt_reg;
    pend_next = pend_reg;
    got_next = got_reg;
    req_next = 1'b0;
    we_next = we_reg;
    pchk_next = 1'b0;
    go_cnt_next = (go_cnt_reg < GO_GO_CYC) ? go_cnt_reg + 4'h1 : go_cnt_reg;
    res_cnt_next = (res_cnt_reg < RES_GO_CYC) ? res_cnt_reg + 4'h1 : res_cnt_reg;
    rdy_next = got_reg & (go_cnt_reg >= GO_GATE_CYC);
    case (st_reg)
      MS_IDLE: begin
        if (go_ok) begin
          maddr_next = ms_sum[W-1:0];
          wr_next = ~main_resume_cmd;
          flt_next = ms_bad;
          pend_next = 1'b0;
          go_cnt_next = '0;
          rdy_next = 1'b0;
          if (main_resume_cmd) res_cnt_next = '0;
          if (ms_bad) begin
            data_next = prot ? '0 : '1;
            pchk_next = 1'b1;
            got_next = 1'b1;
            st_next = main_resume_cmd ? MS_DONE : MS_WAITRES;
          end else begin
            got_next = 1'b0;
            req_next = 1'b1;
            we_next = 1'b0;
            st_next = MS_FETCH;
          end
        end
      end
      MS_FETCH: begin
        if (res_take) begin
          pend_next = 1'b1;
          wdat_next = main_in;
          res_cnt_next = '0;
        end
        if (ms_rvalid) begin
          data_next = ms_rdata;
          got_next = 1'b1;
          if (!wr_reg) begin
            st_next = MS_DONE;
          end else if (pend_reg || res_take) begin
            req_next = 1'b1;
            we_next = 1'b1;
            st_next = MS_DONE;
          end else begin
            st_next = MS_WAITRES;
          end
        end
      end
      MS_WAITRES: begin
        // read word may be gated here before the modified data is resumed
        if (t_step && main_resume_cmd) begin
          res_cnt_next = '0;
          st_next = MS_DONE;
          if (!flt_reg) begin
            req_next = 1'b1;
            we_next = 1'b1;
            wdat_next = main_in;
          end
        end
      end
      MS_DONE: begin
        // busy covers both spacing windows so a new go cannot land early
        if (go_cnt_reg == GO_GO_CYC && res_cnt_reg == RES_GO_CYC) st_next = MS_IDLE;
      end
      default: st_next = MS_IDLE;
    endcase
    busy_next = st_next != MS_IDLE;
    stk_next = pchk_next | (stk_reg & ~pchk_clr);
  end

  // gating the word; destination pointer sampled in the gate step
  always_comb begin
    mob_next = gate_ok ? data_reg : mob_reg;
    lwe_next = gate_ok & (ptr_class(main_output_pointer) == PC_LOCAL);
    ewe_next = gate_ok & (ptr_class(main_output_pointer) == PC_EXT);
    dsel_next = gate_ok ? main_output_pointer : dsel_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= MS_IDLE;
      maddr_reg <= '0;
      data_reg <= '0;
      wdat_reg <= '0;
      mob_reg <= '0;
      wr_reg <= 1'b0;
      flt_reg <= 1'b0;
      pend_reg <= 1'b0;
      got_reg <= 1'b0;
      rdy_reg <= 1'b0;
      busy_reg <= 1'b0;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      pchk_reg <= 1'b0;
      stk_reg <= 1'b0;
      lwe_reg <= 1'b0;
      ewe_reg <= 1'b0;
      dsel_reg <= '0;
      go_cnt_reg <= GO_GO_CYC;
      res_cnt_reg <= RES_GO_CYC;
    end else begin
      st_reg <= st_next;
      maddr_reg <= maddr_next;
      data_reg <= data_next;
      wdat_reg <= wdat_next;
      mob_reg <= mob_next;
      wr_reg <= wr_next;
      flt_reg <= flt_next;
      pend_reg <= pend_next;
      got_reg <= got_next;
      rdy_reg <= rdy_next;
      busy_reg <= busy_next;
      req_reg <= req_next;
      we_reg <= we_next;
      pchk_reg <= pchk_next;
      stk_reg <= stk_next;
      lwe_reg <= lwe_next;
      ewe_reg <= ewe_next;
      dsel_reg <= dsel_next;
      go_cnt_reg <= go_cnt_next;
      res_cnt_reg <= res_cnt_next;
    end
  end

  // external ports: clear then load collapses into one load
  logic [NPORT-1:0] prs_next, pts_next, prs_reg, pts_reg;
  logic [W-1:0] pcap_reg, pcap_next;
  for (genvar i = 0; i < NPORT; i++) begin : g_port
    assign prs_next[i] = t_step & port_read_cmd & (port_select_field == ($clog2(NPORT))'(i));
    assign pts_next[i] = t_step & port_transmit_cmd & (port_select_field == ($clog2(NPORT))'(i));
  end
  always_comb begin
    pcap_next = (t_step & port_read_cmd) ? port_data_in : pcap_reg;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prs_reg <= '0;
      pts_reg <= '0;
      pcap_reg <= '0;
    end else begin
      prs_reg <= prs_next;
      pts_reg <= pts_next;
      pcap_reg <= pcap_next;
    end
  end

  // apb: read data prepared in setup, one access cycle, no wait states
  assign wr_acc = psel & penable & pready & pwrite;
  assign pchk_clr = wr_acc & (paddr == A_STAT) & pwdata[ST_PCHK];
  always_comb begin
    ctrl_next = ctrl_reg;
    base_next = base_reg;
    limit_next = limit_reg;
    size_next = size_reg;
    prdata_next = prdata;
    pslverr_next = 1'b0;
    pready_next = psel & ~penable;
    if (psel && !penable) begin
      pslverr_next = 1'b0;
      case (paddr)
        A_CTRL: prdata_next = {31'h0, ctrl_reg};
        A_BASE: prdata_next = {14'h0, base_reg};
        A_LIMIT: prdata_next = {14'h0, limit_reg};
        A_SIZE: prdata_next = {13'h0, size_reg};
        A_STAT: prdata_next = {29'h0, stk_reg, rdy_reg, busy_reg};
        A_COD: prdata_next = {14'h0, cod_reg};
        default: begin
          prdata_next = 32'h0;
          pslverr_next = 1'b1;
        end
      endcase
    end
    if (wr_acc) begin
      case (paddr)
        A_CTRL: ctrl_next = pwdata[0];
        A_BASE: base_next = pwdata[W-1:0];
        A_LIMIT: limit_next = pwdata[W-1:0];
        A_SIZE: size_next = pwdata[W:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
      base_reg <= BASE_RST;
      limit_reg <= LIMIT_RST;
      size_reg <= SIZE_RST;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      base_reg <= base_next;
      limit_reg <= limit_next;
      size_reg <= size_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  // outputs straight from flops
  assign ctrl_output_bus = cod_reg;
  assign main_busy_test = busy_reg;
  assign main_data_ready_test = rdy_reg;
  assign main_output_bus = mob_reg;
  assign main_local_we = lwe_reg;
  assign main_ext_we = ewe_reg;
  assign main_dest_sel = dsel_reg;
  assign program_check = pchk_reg;
  assign ms_req = req_reg;
  assign ms_we = we_reg;
  assign ms_addr = maddr_reg;
  assign ms_wdata = wdat_reg;
  assign port_read_strobe = prs_reg;
  assign port_transmit_strobe = pts_reg;
  assign port_capture = pcap_reg;

  // checks
  a_cs_oob_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (t_step && (cs_read_cmd || cs_write_cmd) && cs_oob) |=> ctrl_output_bus == '0) else $error("oob not zero");
  a_write_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (cs_wr && cs_read_cmd && !cs_oob) |=> ctrl_output_bus == $past(ctrl_write_data_bus)) else $error("read won");
  a_cod_holds: assert property (@(posedge pclk) disable iff (!presetn)
    !(t_step && (cs_read_cmd || cs_write_cmd)) |=> $stable(ctrl_output_bus)) else $error("cod moved");
  a_go_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    go_ok |-> go_cnt_reg == GO_GO_CYC && res_cnt_reg == RES_GO_CYC) else $error("go too soon");
  a_ready_gap: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(main_data_ready_test) |-> go_cnt_reg > GO_GATE_CYC) else $error("ready early");
  a_limit_check: assert property (@(posedge pclk) disable iff (!presetn)
    (go_ok && prot && main_in > limit_reg) |=> program_check && data_reg == '0) else $error("no check");
  a_direct_ones: assert property (@(posedge pclk) disable iff (!presetn)
    (go_ok && !prot && ms_bad) |=> program_check && data_reg == '1) else $error("not ones");
  a_null_dest: assert property (@(posedge pclk) disable iff (!presetn)
    (t_step && main_data_gate_cmd && main_output_pointer > EXT_LAST) |=> !main_local_we && !main_ext_we)
    else $error("null dest wrote");
  a_gate_word: assert property (@(posedge pclk) disable iff (!presetn)
    gate_ok |=> main_output_bus == $past(data_reg) ##1 !main_local_we || $past(gate_ok)) else $error("gate");
  a_port_read: assert property (@(posedge pclk) disable iff (!presetn)
    (t_step && port_read_cmd) |=> $onehot(port_read_strobe) && port_capture == $past(port_data_in))
    else $error("port read");
  a_port_xmit: assert property (@(posedge pclk) disable iff (!presetn)
    (t_step && port_transmit_cmd) |=> $onehot(port_transmit_strobe) ##1 port_transmit_strobe == '0 ||
    $past(t_step && port_transmit_cmd)) else $error("port xmit");
endmodule
`default_nettype wire

// ### dv/ms_mem_model.sv
// behavioural main store memory that answers the sequencer's requests
`timescale 1ns/1ps
`default_nettype none
module ms_mem_model #(
  parameter int LAT = 4,
  parameter logic [17:0] FILL = 18'h2c3c3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request and answer
  input wire logic ms_req,
  input wire logic ms_we,
  input wire logic [17:0] ms_addr,
  input wire logic [17:0] ms_wdata,
  output logic [17:0] ms_rdata,
  output logic ms_rvalid
);
  logic [17:0] mem [0:255];
  logic [17:0] word;
  logic slow;
  int cnt;
  // answers alternate fast and slow; the data line shows the inverse outside the valid pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 256; i++) begin
        mem[i] <= FILL ^ 18'(i);
      end
      cnt <= 0;
      slow <= 1'b0;
      word <= '0;
      ms_rvalid <= 1'b0;
      ms_rdata <= '1;
    end else begin
      ms_rvalid <= 1'b0;
      ms_rdata <= ~word;
      if (ms_req && ms_we) begin
        mem[ms_addr[7:0]] <= ms_wdata;
      end else if (ms_req) begin
        word <= mem[ms_addr[7:0]];
        cnt <= slow ? LAT : 1;
        slow <= ~slow;
      end else if (cnt == 1) begin
        ms_rvalid <= 1'b1;
        ms_rdata <= word;
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/memory_reference_sequencer_tb_top.sv
// self-checking bench for the memory reference sequencer
`timescale 1ns/1ps
`default_nettype none
module memory_reference_sequencer_tb_top;
  import mrs_pkg::*;
  localparam logic [W-1:0] FILL = 18'h2c3c3;
  localparam logic [W-1:0] DW = 18'h15a5a;
  localparam logic [6:0] C_RD = 7'h40, C_WR = 7'h20, C_GO = 7'h10, C_RES = 7'h08, C_GATE = 7'h04;
  localparam logic [6:0] C_PRD = 7'h02, C_PTX = 7'h01;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, t_step, cs_read_cmd, cs_write_cmd;
  logic main_go_cmd, main_resume_cmd, main_data_gate_cmd, unprotected_main_mode, main_busy_test;
  logic main_data_ready_test, main_local_we, main_ext_we, program_check, ms_req, ms_we, ms_rvalid;
  logic port_read_cmd, port_transmit_cmd, er;
  logic [7:0] paddr, port_read_strobe, port_transmit_strobe;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] cs_addr_sel, port_select_field;
  logic [PW-1:0] main_input_pointer, main_output_pointer, main_dest_sel;
  logic [W-1:0] ctrl_addr_bus, micro_counter, parameter_register, micro_base_bus, index_result;
  logic [W-1:0] ctrl_write_data_bus, ctrl_output_bus, main_local_data, main_ext_data, main_output_bus;
  logic [W-1:0] ms_addr, ms_wdata, ms_rdata, port_data_in, port_capture;
  int bad_count, checks, cyc, t_go;

  memory_reference_sequencer #(.CS_DEPTH(64), .NPORT(8)) dut (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .t_step, .cs_read_cmd, .cs_write_cmd, .cs_addr_sel,
    .ctrl_addr_bus, .micro_counter, .parameter_register, .micro_base_bus, .index_result,
    .ctrl_write_data_bus, .ctrl_output_bus, .main_go_cmd, .main_resume_cmd, .main_data_gate_cmd,
    .unprotected_main_mode, .main_input_pointer, .main_output_pointer, .main_local_data, .main_ext_data,
    .main_busy_test, .main_data_ready_test, .main_output_bus, .main_local_we, .main_ext_we, .main_dest_sel,
    .program_check, .ms_req, .ms_we, .ms_addr, .ms_wdata, .ms_rdata, .ms_rvalid, .port_select_field,
    .port_read_cmd, .port_transmit_cmd, .port_data_in, .port_read_strobe, .port_transmit_strobe,
    .port_capture);
  ms_mem_model #(.LAT(4), .FILL(FILL)) mem (.pclk, .presetn, .ms_req, .ms_we, .ms_addr, .ms_wdata,
    .ms_rdata, .ms_rvalid);

  // clock and cycle count
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // apb master: waits for pready, takes data at that edge only
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one t-step carrying the given commands; returns at the sampling edge
  task automatic step(input logic [6:0] c);
    @(posedge pclk);
    t_step <= 1'b1;
    {cs_read_cmd, cs_write_cmd, main_go_cmd, main_resume_cmd, main_data_gate_cmd, port_read_cmd,
      port_transmit_cmd} <= c;
    @(posedge pclk);
    t_step <= 1'b0;
    {cs_read_cmd, cs_write_cmd, main_go_cmd, main_resume_cmd, main_data_gate_cmd, port_read_cmd,
      port_transmit_cmd} <= '0;
  endtask

  task automatic cs_op(input logic [6:0] c, input logic [2:0] s, input logic [W-1:0] e, input string what);
    cs_addr_sel <= s;
    step(7'h0);
    step(c);
    @(negedge pclk);
    chk(ctrl_output_bus, e, what);
    repeat (3) @(negedge pclk);
    chk(ctrl_output_bus, e, what);
    @(posedge pclk);
  endtask

  task automatic apb_test();
    apb(0, A_CTRL, 0);
    chk(rd, 32'(CTRL_RST), "ctrl reset");
    apb(0, A_LIMIT, 0);
    chk(rd, 32'(LIMIT_RST), "limit reset");
    apb(0, A_SIZE, 0);
    chk(rd, 32'(SIZE_RST), "size reset");
    apb(1, 8'h1c, 32'h1);
    chk(er, 1'b1, "unmapped write");
    apb(0, 8'h18, 0);
    chk({er, rd[30:0]}, 32'h80000000, "unmapped read");
  endtask

  task automatic cs_test();
    int s;
    ctrl_addr_bus <= 18'h7;
    ctrl_write_data_bus <= 18'h5;
    cs_op(C_WR, 3'h0, 18'h5, "cs write");
    ctrl_addr_bus <= 18'h5;
    ctrl_write_data_bus <= DW;
    cs_op(C_WR | C_RD, 3'h0, DW, "write wins");
    ctrl_addr_bus <= 18'h40;
    cs_op(C_WR, 3'h0, 18'h0, "missing location");
    for (s = 1; s < 8; s++) begin
      ctrl_addr_bus <= 18'h7;
      cs_op(C_RD, 3'h0, 18'h5, "read seven");
      ctrl_addr_bus <= 18'h9;
      micro_counter <= (s == 2) ? 18'h5 : (s == 3) ? 18'h4 : (s == 4 || s == 5) ? 18'h3 : 18'h9;
      parameter_register <= (s == 5 || s == 6) ? 18'h2 : 18'h0;
      micro_base_bus <= (s == 6) ? 18'h3 : 18'h9;
      index_result <= (s == 7) ? 18'h5 : 18'h9;
      cs_op(C_RD, 3'(s), DW, "address source");
    end
    apb(0, A_COD, 0);
    chk(rd, 32'(DW), "output bus register");
  endtask

  task automatic ms_start(input logic [6:0] c, input logic [PW-1:0] p, input logic [W-1:0] v, input logic u,
                          input logic [W-1:0] ea, input logic f, input string what);
    main_input_pointer <= p;
    main_local_data <= (p < 6'h20) ? v : ~v;
    main_ext_data <= (p < 6'h20) ? ~v : v;
    unprotected_main_mode <= u;
    step(c);
    t_go = cyc;
    @(negedge pclk);
    chk(program_check, f, what);
    chk({ms_req, ms_we}, {!f, 1'b0}, what);
    if (!f) chk(ms_addr, ea, what);
  endtask

  task automatic wait_ready();
    while (main_data_ready_test !== 1'b1 && cyc - t_go < 60) @(negedge pclk);
    chk(cyc - t_go >= GO_GATE_CYC && cyc - t_go < 60, 1'b1, "ready time");
    @(posedge pclk);
  endtask

  task automatic gate(input logic [PW-1:0] p, input logic [W-1:0] e, input logic [1:0] we, input string what);
    main_output_pointer <= p;
    step(C_GATE);
    @(negedge pclk);
    chk(main_output_bus, e, what);
    chk({main_ext_we, main_local_we, main_dest_sel}, {we, p}, what);
    @(posedge pclk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (main_busy_test !== 1'b0 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk(n < 60, 1'b1, "busy stuck");
    repeat (RES_GO_CYC) @(posedge pclk);
  endtask

  task automatic ms_test();
    apb(1, A_BASE, 32'h10);
    apb(1, A_LIMIT, 32'h20);
    apb(1, A_SIZE, 32'h40);
    ms_start(C_GO | C_RES, 6'h3, 18'h5, 0, 18'h15, 0, "read");
    step(C_GO | C_RES);
    @(negedge pclk);
    chk(ms_req, 1'b0, "go while busy");
    wait_ready();
    gate(6'h2, FILL ^ 18'h15, 2'b01, "gate local");
    wait_idle();
    ms_start(C_GO | C_RES, 6'h21, 18'h6, 0, 18'h16, 0, "ext source");
    wait_ready();
    gate(6'h2d, FILL ^ 18'h16, 2'b00, "null dest");
    wait_idle();
    ms_start(C_GO | C_RES, 6'h3, 18'h21, 0, 0, 1, "above limit");
    apb(0, A_STAT, 0);
    chk(rd[ST_PCHK], 1'b1, "check sticky");
    wait_idle();
    ms_start(C_GO | C_RES, 6'h3, 18'h30, 1, 18'h30, 0, "direct");
    wait_ready();
    gate(6'h4, FILL ^ 18'h30, 2'b01, "direct data");
    wait_idle();
    ms_start(C_GO | C_RES, 6'h2d, 18'h0, 1, 0, 1, "ones beyond size");
    wait_idle();
    apb(1, A_CTRL, 0);
    ms_start(C_GO | C_RES, 6'h3, 18'h31, 0, 18'h31, 0, "no option");
    wait_ready();
    gate(6'h22, FILL ^ 18'h31, 2'b10, "gate ext");
    apb(1, A_CTRL, 1);
    wait_idle();
    ms_start(C_GO, 6'h3, 18'h8, 0, 18'h18, 0, "rmw go");
    wait_ready();
    gate(6'h1, FILL ^ 18'h18, 2'b01, "rmw read");
    main_local_data <= 18'h2abcd;
    step(C_RES);
    @(negedge pclk);
    chk({ms_req, ms_we, ms_addr[11:0], ms_wdata}, {2'b11, 12'h18, 18'h2abcd}, "rmw write");
    wait_idle();
    ms_start(C_GO | C_RES, 6'h3, 18'h8, 0, 18'h18, 0, "read back");
    wait_ready();
    gate(6'h1, 18'h2abcd, 2'b01, "written word");
    wait_idle();
  endtask

  task automatic port_test();
    for (int k = 0; k < 8; k++) begin
      port_select_field <= 3'(k);
      port_data_in <= 18'h3a000 + 18'(k);
      step(C_PRD);
      @(negedge pclk);
      chk({port_read_strobe, port_capture}, {8'h1 << k, 18'h3a000 + 18'(k)}, "port read");
      @(posedge pclk);
      port_data_in <= 18'h0;
      step(C_PTX);
      @(negedge pclk);
      chk({port_transmit_strobe, port_read_strobe}, {8'h1 << k, 8'h0}, "port transmit");
      @(posedge pclk);
    end
  endtask

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, t_step, cs_read_cmd, cs_write_cmd, main_go_cmd} = '0;
    {main_resume_cmd, main_data_gate_cmd, unprotected_main_mode, port_read_cmd, port_transmit_cmd} = '0;
    {paddr, pwdata, cs_addr_sel, port_select_field, main_input_pointer, main_output_pointer} = '0;
    {ctrl_addr_bus, micro_counter, parameter_register, micro_base_bus, index_result} = '0;
    {ctrl_write_data_bus, main_local_data, main_ext_data, port_data_in} = '0;
    {bad_count, checks} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb_test();
    cs_test();
    ms_test();
    port_test();
    finish_test();
  end

  // watchdog far beyond the expected run length
  initial begin
    #(30000 * 100);
    bad_count++;
    $display("FAIL %0t watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
